//--- src/aod_demux.sv
// Purpose: Output stage of an 8-bit converter: pipeline, buffer and bank demux.
// Assumes: One Gray-coded comparator word per enabled cycle on sample_gray_i.
// Notes:   Banks and strobe are three-state pins given as data plus enable.
//
// Contract
// - Three cycle pipeline latency before buffer and banks.
// - Low three bits latched with the upper bits.
// - Two select inputs choose one of three modes.
// - Single mode: bank A only, half rate.
// - Interleaved mode alternates bank A and B.
// - Parallel mode delays A, pair updates together.
// - Divide-by-two phase picks bank in dual modes.
// - Align reset forces bank-select phase to bank A.
// - Align reset acts only in dual modes.
// - Strobe latches single data, shows bank otherwise.
// - Output code is straight binary, monotonic.
// - Power-down stops activity, tri-states banks and strobe.
`timescale 1ns/1ps
`default_nettype none

module aod_demux
    import aod_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic [DATA_W-1:0] sample_gray_i,
    input  wire logic              sample_valid_i,
    output logic                   sample_ready_o,
    input  wire logic              out_mode_sel_first_i,
    input  wire logic              out_mode_sel_second_i,
    input  wire logic              align_reset_p_i,
    input  wire logic              align_reset_n_i,
    input  wire logic              power_down_in_i,
    input  wire logic              out_ready_i,
    output logic      [DATA_W-1:0] bank_a_data_o,
    output logic                   bank_a_oe_o,
    output logic      [DATA_W-1:0] bank_b_data_o,
    output logic                   bank_b_oe_o,
    output logic                   data_out_strobe_p_o,
    output logic                   data_out_strobe_n_o,
    output logic                   data_out_strobe_oe_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              v1;
        logic [MSB_W-1:0]  msb1;
        logic [MID_W-1:0]  mid1;
        logic [LSB_W-1:0]  lsb_pend1;
        logic              v2;
        logic [MSB_W-1:0]  msb2;
        logic [MID_W-1:0]  mid2;
        logic [LSB_W-1:0]  lsb2;
        logic              v3;
        logic [DATA_W-1:0] word3;
        logic              phase;
        logic              gap;
        logic [DATA_W-1:0] hold;
        logic [DATA_W-1:0] bank_a;
        logic [DATA_W-1:0] bank_b;
        logic              strobe;
    } aod_st_t;

    aod_st_t           s_q;
    aod_st_t           s_d;
    aod_mode_t         mode;
    logic              dual_mode;
    logic              align_req;
    logic              advance;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic              pop;
    logic              eff_phase;
    logic              single_mode;
    logic              align_active;
    logic              fifo_push;
    logic              pins_on;

    // ------------------------------------------------------------------
    // Bank slot decode
    // ------------------------------------------------------------------
    // True when the given divider phase selects bank A.
    function automatic logic aod_slot_is_a(input logic phase);
        return (phase == BANK_A_SEL);
    endfunction

    // ------------------------------------------------------------------
    // Mode, alignment and flow control
    // ------------------------------------------------------------------
    assign mode         = aod_mode_decode(out_mode_sel_first_i, out_mode_sel_second_i);
    assign single_mode  = (mode == AOD_MODE_SGL);
    assign dual_mode    = !single_mode;
    assign align_active = align_reset_p_i && !align_reset_n_i;
    assign align_req    = align_active && dual_mode;
    // The whole pipeline stalls when the buffer is full and stage 3 holds a valid word.
    assign advance        = !power_down_in_i && (fifo_in_ready || !s_q.v3);
    assign sample_ready_o = advance;
    assign fifo_push      = s_q.v3 && advance;
    // Single mode may only take one result every second cycle.
    assign pop       = fifo_out_valid && out_ready_i && !power_down_in_i
                       && !(single_mode && s_q.gap);
    assign eff_phase = align_req ? BANK_A_SEL : s_q.phase;

    // ------------------------------------------------------------------
    // Buffer between pipeline and bank selection
    // ------------------------------------------------------------------
    aod_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .clk_en_i    (clk_en_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (s_q.word3),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (advance) begin
            // Stage 1 takes all bits of the sample: upper, middle and low.
            s_d.v1        = sample_valid_i;
            s_d.msb1      = sample_gray_i[DATA_W-1 -: MSB_W];
            s_d.mid1      = sample_gray_i[LSB_W +: MID_W];
            s_d.lsb_pend1 = sample_gray_i[LSB_W-1:0];
            // Stage 2 latches the low bits in the same cycle as the upper bits.
            s_d.v2   = s_q.v1;
            s_d.msb2 = s_q.msb1;
            s_d.mid2 = s_q.mid1;
            s_d.lsb2 = s_q.lsb_pend1;
            // Stage 3 completes the latency before bank selection.
            s_d.v3    = s_q.v2;
            s_d.word3 = aod_gray2bin({s_q.msb2, s_q.mid2, s_q.lsb2});
        end

        s_d.phase = eff_phase;
        s_d.gap   = pop && single_mode;

        // Bank routing of the popped result.
        if (pop) begin
            case (mode)
                AOD_MODE_SGL: begin
                    s_d.bank_a = fifo_out_data;
                end
                AOD_MODE_ILV: begin
                    if (aod_slot_is_a(eff_phase)) begin
                        s_d.bank_a = fifo_out_data;
                    end else begin
                        s_d.bank_b = fifo_out_data;
                    end
                end
                AOD_MODE_PAR: begin
                    if (aod_slot_is_a(eff_phase)) begin
                        s_d.hold = fifo_out_data;
                    end else begin
                        s_d.bank_a = s_q.hold;
                        s_d.bank_b = fifo_out_data;
                    end
                end
                default: begin
                    s_d.bank_a = s_q.bank_a;
                end
            endcase
            if (dual_mode) begin
                s_d.phase = !eff_phase;
            end
        end

        // Strobe is a latch pulse in single mode and a bank flag otherwise.
        if (single_mode) begin
            s_d.strobe = pop;
        end else if (pop) begin
            s_d.strobe = aod_slot_is_a(eff_phase);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            // Reset puts the bank-select divider on the bank A phase.
            s_q        <= '0;
            s_q.phase  <= RST_PHASE;
            s_q.gap    <= RST_GAP;
            s_q.strobe <= RST_STROBE;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    assign bank_a_data_o        = s_q.bank_a;
    assign bank_b_data_o        = s_q.bank_b;
    assign data_out_strobe_p_o  = s_q.strobe;
    assign data_out_strobe_n_o  = !s_q.strobe;
    // Enables are combinational so power down releases the pins at once.
    assign pins_on              = !power_down_in_i;
    assign bank_a_oe_o          = pins_on;
    assign bank_b_oe_o          = pins_on;
    assign data_out_strobe_oe_o = pins_on;

endmodule // aod_demux

`default_nettype wire

//--- src/aod_pkg.sv
// Purpose: Shared constants, types and decode functions of the converter output demux.
// Assumes: One sample clock; all inputs synchronous to it.
// Notes:   Offsets are absent; the block has plain control and status ports.
`default_nettype none

package aod_pkg;

    // ------------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned MSB_W      = 3;
    localparam int unsigned MID_W      = 2;
    localparam int unsigned LSB_W      = 3;
    localparam int unsigned FIFO_DEPTH = 16;

    // ------------------------------------------------------------------
    // Latency, counted in half sample-clock cycles and in whole cycles
    // ------------------------------------------------------------------
    localparam int unsigned LAT_HALF_CYC = 5;
    localparam int unsigned LAT_CYC      = (LAT_HALF_CYC + 1) / 2;

    // ------------------------------------------------------------------
    // Values after reset, and the phase that selects bank A
    // ------------------------------------------------------------------
    localparam logic RST_PHASE  = 1'b0;
    localparam logic RST_STROBE = 1'b0;
    localparam logic RST_GAP    = 1'b0;
    localparam logic BANK_A_SEL = 1'b0;

    // ------------------------------------------------------------------
    // Output modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AOD_MODE_PAR,
        AOD_MODE_ILV,
        AOD_MODE_SGL
    } aod_mode_t;

    // Maps the two mode-select inputs to an output mode.
    function automatic aod_mode_t aod_mode_decode(input logic sel_first, input logic sel_second);
        aod_mode_t m;
        m = AOD_MODE_SGL;
        if (!sel_first) begin
            m = sel_second ? AOD_MODE_ILV : AOD_MODE_PAR;
        end
        return m;
    endfunction

    // Converts a comparator Gray word to straight binary.
    function automatic logic [DATA_W-1:0] aod_gray2bin(input logic [DATA_W-1:0] g);
        logic [DATA_W-1:0] b;
        b = '0;
        b[DATA_W-1] = g[DATA_W-1];
        for (int i = DATA_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

`default_nettype wire

//--- src/aod_fifo.sv
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty are exact; a push into a full FIFO is refused.
`timescale 1ns/1ps
`default_nettype none

module aod_fifo
    import aod_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             clk_en_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int unsigned AW       = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } aod_fifo_st_t;

    aod_fifo_st_t s_q;
    aod_fifo_st_t s_d;
    logic         push;
    logic         pop;

    assign in_ready_o  = (s_q.count != FULL_CNT);
    assign out_valid_o = (s_q.count != '0);
    assign out_data_o  = s_q.mem[s_q.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr_ptr] = in_data_i;
            s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        case ({push, pop})
            2'b10:   s_d.count = s_q.count + 1'b1;
            2'b01:   s_d.count = s_q.count - 1'b1;
            default: s_d.count = s_q.count;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else if (clk_en_i) begin
            s_q <= s_d;
        end
    end

endmodule // aod_fifo

`default_nettype wire

//--- test/aod_demux_properties.sv
// Purpose: Port assertions of the output demux.
// Assumes: Modes change only while reset is held.
// Notes:   Bound into every aod_demux.
`timescale 1ns/1ps
`default_nettype none
module aod_demux_chk
    import aod_pkg::*;
(
    input wire logic              ref_clk_i,
    input wire logic              rst_n_i,
    input wire logic              out_mode_sel_first_i,
    input wire logic              out_mode_sel_second_i,
    input wire logic              align_reset_p_i,
    input wire logic              align_reset_n_i,
    input wire logic              power_down_in_i,
    input wire logic              sample_ready_o,
    input wire logic [DATA_W-1:0] bank_a_data_o,
    input wire logic              bank_a_oe_o,
    input wire logic [DATA_W-1:0] bank_b_data_o,
    input wire logic              bank_b_oe_o,
    input wire logic              data_out_strobe_p_o,
    input wire logic              data_out_strobe_n_o,
    input wire logic              data_out_strobe_oe_o
);
    // --------------------
    // Port relations
    // --------------------
    logic ilv, par, al;
    assign ilv = !out_mode_sel_first_i && out_mode_sel_second_i;
    assign par = !out_mode_sel_first_i && !out_mode_sel_second_i;
    assign al  = align_reset_p_i && !align_reset_n_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_oe_off_pd: assert property (
        {bank_a_oe_o, bank_b_oe_o, data_out_strobe_oe_o} == {3{!power_down_in_i}})
        else $error("output enables do not follow power down");
    a_pd_no_take: assert property (power_down_in_i |-> !sample_ready_o)
        else $error("input taken in power down");
    a_pd_hold: assert property (
        power_down_in_i |=> $stable(bank_a_data_o) && $stable(bank_b_data_o))
        else $error("banks moved in power down");
    a_strobe_pair: assert property (data_out_strobe_n_o == !data_out_strobe_p_o)
        else $error("strobe pair not complementary");
    a_sgl_no_b: assert property (out_mode_sel_first_i |=> $stable(bank_b_data_o))
        else $error("bank B written in single mode");
    a_sgl_pulse: assert property (
        out_mode_sel_first_i && $rose(data_out_strobe_p_o) |=> !data_out_strobe_p_o)
        else $error("single mode strobe too long");
    a_ilv_a_slot: assert property ($past(ilv) && $changed(bank_a_data_o) |-> data_out_strobe_p_o)
        else $error("bank A written outside its slot");
    a_ilv_b_slot: assert property ($past(ilv) && $changed(bank_b_data_o) |-> !data_out_strobe_p_o)
        else $error("bank B written outside its slot");
    a_par_pair: assert property ($past(par) && $changed(bank_a_data_o) |-> !data_out_strobe_p_o)
        else $error("parallel bank A not paired");
    a_align_slot_a: assert property (
        !out_mode_sel_first_i && al && !power_down_in_i |=> $stable(bank_b_data_o))
        else $error("aligned pop went to bank B");
endmodule // aod_demux_chk
bind aod_demux aod_demux_chk u_aod_demux_chk (.ref_clk_i, .rst_n_i, .out_mode_sel_first_i,
    .out_mode_sel_second_i, .align_reset_p_i, .align_reset_n_i, .power_down_in_i,
    .sample_ready_o, .bank_a_data_o, .bank_a_oe_o, .bank_b_data_o, .bank_b_oe_o,
    .data_out_strobe_p_o, .data_out_strobe_n_o, .data_out_strobe_oe_o);
`default_nettype wire

//--- test/aod_capture.sv
// Purpose: Downstream capture logic latching the output banks.
// Assumes: Mode is fixed between resets.
// Notes:   Captured words are kept in arrival order.
`timescale 1ns/1ps
`default_nettype none
module aod_capture
    import aod_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              stall_i,
    input  wire logic              mode_first_i,
    input  wire logic              mode_second_i,
    input  wire logic [DATA_W-1:0] bank_a_i,
    input  wire logic [DATA_W-1:0] bank_b_i,
    input  wire logic              strobe_i,
    output logic                   ready_o
);
    // --------------------
    // Capture
    // --------------------
    logic [DATA_W-1:0] got[$];
    logic              strobe_q;
    assign ready_o = !stall_i;
    always @(posedge ref_clk_i) begin
        strobe_q <= strobe_i;
        if (!rst_n_i) begin
            got.delete();
        end else if (mode_first_i) begin
            if (strobe_i) got.push_back(bank_a_i);
        end else if (strobe_i != strobe_q) begin
            if (strobe_i && mode_second_i) got.push_back(bank_a_i);
            if (!strobe_i && !mode_second_i) got.push_back(bank_a_i);
            if (!strobe_i) got.push_back(bank_b_i);
        end
    end
endmodule // aod_capture
`default_nettype wire

//--- test/aod_demux_test.sv
// Purpose: Self-checking bench of the output demux.
// Assumes: Capture model on the bank side.
// Notes:   Expected words are the binary values sent.
`timescale 1ns/1ps
`default_nettype none
module aod_demux_test
    import aod_pkg::*;
;
    // --------------------
    // Bench
    // --------------------
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, sel1 = 1'b0, sel2 = 1'b0, pd = 1'b0;
    logic stall = 1'b0, hold = 1'b0, rnd = 1'b0, alp = 1'b0, aln = 1'b1;
    logic rdy, ordy, aoe, boe, sp, soe;
    logic [DATA_W-1:0] gray = 8'h00, ba, bb, exp_q[$];
    integer seed = 32'h7dfcefcb, n_fail = 0, checks_done = 0, n;
    always #2.5 clk = ~clk;
    always @(posedge clk) stall <= hold || (rnd && ($random(seed) % 3 == 0));
    aod_demux u_aod_demux (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
        .sample_gray_i(gray), .sample_valid_i(vld), .sample_ready_o(rdy),
        .out_mode_sel_first_i(sel1), .out_mode_sel_second_i(sel2), .align_reset_p_i(alp),
        .align_reset_n_i(aln), .power_down_in_i(pd), .out_ready_i(ordy), .bank_a_data_o(ba),
        .bank_a_oe_o(aoe), .bank_b_data_o(bb), .bank_b_oe_o(boe), .data_out_strobe_p_o(sp),
        .data_out_strobe_n_o(), .data_out_strobe_oe_o(soe));
    aod_capture u_aod_capture (.ref_clk_i(clk), .rst_n_i(rst_n), .stall_i(stall),
        .mode_first_i(sel1), .mode_second_i(sel2), .bank_a_i(ba), .bank_b_i(bb),
        .strobe_i(sp), .ready_o(ordy));
    function automatic logic [DATA_W-1:0] enc(input logic [DATA_W-1:0] b);
        return b ^ (b >> 1);
    endfunction
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic send(input logic [DATA_W-1:0] b);
        logic r;
        gray <= enc(b);
        vld <= 1'b1;
        exp_q.push_back(b);
        do begin
            @(negedge clk);
            r = rdy;
            @(posedge clk);
        end while (!r);
    endtask
    task automatic burst(input int k);
        send(8'h00);
        send(8'hff);
        send(8'h7f);
        send(8'h80);
        repeat (k) send(8'($random(seed)));
    endtask
    task automatic restart(input logic f, input logic s);
        rst_n <= 1'b0;
        sel1 <= f;
        sel2 <= s;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        exp_q.delete();
    endtask
    task automatic drain(input string name);
        vld <= 1'b0;
        for (int i = 0; i < 600 && u_aod_capture.got.size() < exp_q.size(); i++) @(posedge clk);
        #1;
        chk(DATA_W'(u_aod_capture.got.size()), DATA_W'(exp_q.size()));
        while (exp_q.size() > 0 && u_aod_capture.got.size() > 0) begin
            chk(u_aod_capture.got.pop_front(), exp_q.pop_front());
        end
        $display("test %s done", name);
        @(posedge clk);
    endtask
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
    initial begin
        restart(1'b0, 1'b1);
        send(8'h5a);
        vld <= 1'b0;
        n = 1;
        while (u_aod_capture.got.size() == 0 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(DATA_W'(n), DATA_W'(LAT_CYC + 3));
        drain("latency");
        rnd <= 1'b1;
        burst(40);
        drain("interleaved");
        alp <= 1'b1;
        aln <= 1'b0;
        @(posedge clk);
        alp <= 1'b0;
        aln <= 1'b1;
        send(8'h3c);
        send(8'hc3);
        vld <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
        chk(ba, 8'h3c);
        chk(bb, 8'hc3);
        exp_q.delete();
        u_aod_capture.got.delete();
        drain("align");
        restart(1'b0, 1'b0);
        burst(40);
        drain("parallel");
        restart(1'b1, 1'($random(seed)));
        alp <= 1'b1;
        aln <= 1'b0;
        burst(20);
        drain("single");
        alp <= 1'b0;
        aln <= 1'b1;
        restart(1'b0, 1'b1);
        rnd <= 1'b0;
        hold <= 1'b1;
        burst(FIFO_DEPTH - 1);
        vld <= 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h00, rdy}, 8'h00);
        pd <= 1'b1;
        hold <= 1'b0;
        @(negedge clk);
        chk({5'h00, aoe, boe, soe}, 8'h00);
        @(negedge clk);
        chk({7'h00, sp}, 8'h00);
        pd <= 1'b0;
        drain("fill and power down");
        final_report();
    end
endmodule // aod_demux_test
`default_nettype wire
